// *** verilog/adc_readout_pkg.sv ***
// Shared constants and types for the converter readout control block.
// Assumes a single 20 MHz core clock and pins that arrive asynchronously.
//
// What this block does
// - Update result register, then release busy high.
// - Old result stays readable 1.5 us after convert.
// - Convert falling starts; convert rising enables bus.
// - Conversion completes within 2.2 us.
// - New result precedes busy rising by 35 ns.
// - Convert falling during conversion aborts and resets.
// - Bus driven only when convert high, select low.
// - Result as full word or byte-selected halves.
// - Select and convert combined, level sensitive, either first.
package adc_readout_pkg;

    // Width of the conversion result and of one byte lane.
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;

    // Core clock period.
    localparam int CLK_PERIOD_NS = 50;

    // Longest conversion time, rounded down to whole cycles.
    localparam int CONV_MAX_NS = 2200;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

    // Least time the previous result stays valid, rounded up.
    localparam int PREV_VALID_NS = 1500;
    localparam int PREV_VALID_CYC = (PREV_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Least lead of new data ahead of the busy rising edge, rounded up.
    localparam int DATA_LEAD_NS = 35;
    localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Latency from a pin edge to the registered response (two sync stages and the state register).
    localparam int SYNC_LAT_CYC = 3;

    // Cycles spent in the converting state, so that the whole busy period fits the limit.
    localparam int CONV_CYC = CONV_MAX_CYC - SYNC_LAT_CYC - DATA_LEAD_CYC;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

    // Pin synchroniser bit positions and idle levels.
    localparam int PIN_SEL = 0;
    localparam int PIN_CONV = 1;
    localparam int PIN_BYTE = 2;
    localparam int PIN_N = 3;
    localparam logic [PIN_N-1:0] PIN_IDLE = 3'h3;

    // Reset value of the held result.
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

    // Control states, Gray coded along idle, convert, done.
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } convState_t;

endpackage

// *** verilog/result_hold.sv ***
// Result holding register with byte-lane selection for the parallel bus.
// Assumes load and lane select come from logic on the same core clock.
`timescale 1ns/100ps
`default_nettype none

module result_hold
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic loadEn,
    input wire logic [adc_readout_pkg::RESULT_W-1:0] newWord,
    input wire logic laneSwap,
    output logic [adc_readout_pkg::RESULT_W-1:0] outWord
);

    // Last completed conversion result.
    logic [adc_readout_pkg::RESULT_W-1:0] holdWord_q;
    // Word to be presented from the next cycle, before lane mapping.
    logic [adc_readout_pkg::RESULT_W-1:0] wordNow;

    // A load bypasses the holding register so the bus sees the new word in the cycle after the load.
    assign wordNow = loadEn ? newWord : holdWord_q;

    // Keeps the result until the next completed conversion.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            holdWord_q <= adc_readout_pkg::RESULT_RESET;
        end
        else if (loadEn)
        begin
            holdWord_q <= newWord;
        end
    end

    // Registered lane mapping: full word, or the upper byte moved to the low lanes.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outWord <= adc_readout_pkg::RESULT_RESET;
        end
        else if (laneSwap)
        begin
            outWord <= {wordNow[adc_readout_pkg::BYTE_W-1:0],
                         wordNow[adc_readout_pkg::RESULT_W-1:adc_readout_pkg::BYTE_W]};
        end
        else
        begin
            outWord <= wordNow;
        end
    end

    // Without a load and with a steady lane choice the presented data do not move.
    property p_hold_stable;
        @(posedge core_clk) disable iff (sys_rst)
        (!loadEn && $stable(laneSwap)) ##1 !loadEn |-> $stable(outWord);
    endproperty
    a_hold_stable: assert property (p_hold_stable) else $error("held result changed without a load");

    // Swapped lanes carry the upper byte low and the lower byte high.
    property p_lane_swap;
        @(posedge core_clk) disable iff (sys_rst)
        (laneSwap && !loadEn) |=> outWord == {$past(holdWord_q[7:0]), $past(holdWord_q[15:8])};
    endproperty
    a_lane_swap: assert property (p_lane_swap) else $error("byte lanes not swapped as selected");

endmodule

`default_nettype wire

// *** verilog/adc_readout_ctrl.sv ***
// Conversion start, busy flag, abort and parallel result readout control.
// Assumes asynchronous select, convert and byte pins, and a convWord on core_clk
// that is final in the cycle that the conversion count ends.
`timescale 1ns/100ps
`default_nettype none

module adc_readout_ctrl
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic chipSelN,
    input wire logic readConvN,
    input wire logic byteSel,
    input wire logic [adc_readout_pkg::RESULT_W-1:0] convWord,
    output logic busyN_q,
    output logic sampleHold_q,
    output logic [adc_readout_pkg::RESULT_W-1:0] result_bus,
    output logic resultBusOe_q
);

    // Pin bundle gathered for the synchroniser loop.
    logic [adc_readout_pkg::PIN_N-1:0] pinRaw;
    // First and second synchroniser stages.
    logic [adc_readout_pkg::PIN_N-1:0] sync1_q;
    logic [adc_readout_pkg::PIN_N-1:0] sync2_q;
    // Synchronised pin levels.
    logic chipSelS;
    logic readConvS;
    logic byteSelS;
    // Combined start level and its previous value for edge detection.
    logic startLvl;
    logic startLvl_q;
    // Previous convert level for the abort edge.
    logic readConvS_q;
    // Detected events.
    logic startRise;
    logic convFall;
    logic abortEv;
    logic loadEn;
    // Control state and conversion counter.
    adc_readout_pkg::convState_t state_q;
    adc_readout_pkg::convState_t state_d;
    logic [adc_readout_pkg::CNT_W-1:0] convCnt_q;
    // Bus enable level at the pins and cycles spent with busy low, used only by checks.
    logic busEnPin;
    logic [adc_readout_pkg::CNT_W-1:0] busyLowCnt_q;

    assign pinRaw = {byteSel, readConvN, chipSelN};

    // Two flip-flops per pin before any logic looks at it.
    genvar gi;
    generate
        for (gi = 0; gi < adc_readout_pkg::PIN_N; gi++)
        begin : g_sync
            always_ff @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_q[gi] <= adc_readout_pkg::PIN_IDLE[gi];
                    sync2_q[gi] <= adc_readout_pkg::PIN_IDLE[gi];
                end
                else
                begin
                    sync1_q[gi] <= pinRaw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign chipSelS = sync2_q[adc_readout_pkg::PIN_SEL];
    assign readConvS = sync2_q[adc_readout_pkg::PIN_CONV];
    assign byteSelS = sync2_q[adc_readout_pkg::PIN_BYTE];

    // Select and convert act together as levels; whichever falls last starts a conversion.
    assign startLvl = !chipSelS && !readConvS;

    // Edge stage for the start level and the convert line.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            startLvl_q <= 1'b0;
            readConvS_q <= 1'b1;
        end
        else
        begin
            startLvl_q <= startLvl;
            readConvS_q <= readConvS;
        end
    end

    // A start needs the combined level to rise, so a line left low after an abort starts nothing.
    assign startRise = startLvl && !startLvl_q;
    assign convFall = !readConvS && readConvS_q;

    // A new convert edge while converting halts the conversion, whatever the select line does.
    assign abortEv = (state_q == adc_readout_pkg::ST_CONV) && (convFall || startRise);

    // The result is taken on the last counted cycle of an uninterrupted conversion.
    assign loadEn = (state_q == adc_readout_pkg::ST_CONV) && !abortEv
                    && (convCnt_q == adc_readout_pkg::CONV_LAST);

    // Next state: idle waits for a start, convert counts or aborts, done hands back to idle.
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            adc_readout_pkg::ST_IDLE:
            begin
                // A rising start level begins conversion.
                if (startRise)
                begin
                    state_d = adc_readout_pkg::ST_CONV;
                end
            end
            adc_readout_pkg::ST_CONV:
            begin
                // Abort resets the converter; a finished count goes to done.
                if (abortEv)
                begin
                    state_d = adc_readout_pkg::ST_IDLE;
                end
                else if (loadEn)
                begin
                    state_d = adc_readout_pkg::ST_DONE;
                end
            end
            adc_readout_pkg::ST_DONE:
            begin
                // One cycle with the new data out and busy still low.
                state_d = adc_readout_pkg::ST_IDLE;
            end
            default:
            begin
                state_d = adc_readout_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= adc_readout_pkg::ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Conversion counter, cleared whenever the block is not converting.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            convCnt_q <= adc_readout_pkg::CNT_RESET;
        end
        else if (state_d == adc_readout_pkg::ST_CONV && state_q == adc_readout_pkg::ST_CONV)
        begin
            convCnt_q <= convCnt_q + 6'h01;
        end
        else
        begin
            convCnt_q <= adc_readout_pkg::CNT_RESET;
        end
    end

    // Busy is low while converting and for the data lead cycle; it rises after the result update.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busyN_q <= 1'b1;
        end
        else
        begin
            busyN_q <= (state_d == adc_readout_pkg::ST_IDLE);
        end
    end

    // Sample and hold sits in hold for the whole conversion.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sampleHold_q <= 1'b0;
        end
        else
        begin
            sampleHold_q <= (state_d == adc_readout_pkg::ST_CONV);
        end
    end

    // The bus is driven only with convert high and select low, otherwise it floats.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resultBusOe_q <= 1'b0;
        end
        else
        begin
            resultBusOe_q <= !chipSelS && readConvS;
        end
    end

    // The previous result stays in the holding register until the load, past the valid window.
    result_hold u_hold
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .loadEn(loadEn),
        .newWord(convWord),
        .laneSwap(byteSelS),
        .outWord(result_bus)
    );

    assign busEnPin = !chipSelN && readConvN;

    // Counts cycles with busy low, so the valid-window check needs no long repetition.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busyLowCnt_q <= adc_readout_pkg::CNT_RESET;
        end
        else
        begin
            busyLowCnt_q <= busyN_q ? adc_readout_pkg::CNT_RESET : busyLowCnt_q + 6'h01;
        end
    end

    // Rising start level seen while idle.
    sequence s_start;
        (state_q == adc_readout_pkg::ST_IDLE) && startRise;
    endsequence

    // Abort request seen during a conversion.
    sequence s_abort;
        (state_q == adc_readout_pkg::ST_CONV) ##0 convFall;
    endsequence

    property p_start_busy;
        @(posedge core_clk) disable iff (sys_rst)
        s_start |=> !busyN_q && sampleHold_q;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("busy did not fall on a start");

    property p_conv_bound;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(busyN_q) |-> ##[1:41] busyN_q;
    endproperty
    a_conv_bound: assert property (p_conv_bound) else $error("conversion ran past its limit");

    property p_load_then_busy;
        @(posedge core_clk) disable iff (sys_rst)
        loadEn |=> !busyN_q && result_bus == ($past(byteSelS) ? {$past(convWord[7:0]), $past(convWord[15:8])}
                   : $past(convWord)) ##1 $rose(busyN_q);
    endproperty
    a_load_then_busy: assert property (p_load_then_busy) else $error("busy rose without a data lead");

    property p_busy_needs_cause;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(busyN_q) |-> $past(state_q) == adc_readout_pkg::ST_DONE || $past(abortEv);
    endproperty
    a_busy_needs_cause: assert property (p_busy_needs_cause) else $error("busy rose without result or abort");

    property p_abort;
        @(posedge core_clk) disable iff (sys_rst)
        s_abort |=> busyN_q && state_q == adc_readout_pkg::ST_IDLE && convCnt_q == 6'h00;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not reset the converter");

    property p_no_restart_low;
        @(posedge core_clk) disable iff (sys_rst)
        abortEv ##1 startLvl |-> busyN_q;
    endproperty
    a_no_restart_low: assert property (p_no_restart_low) else $error("restarted without convert returning high");

    property p_bus_enable;
        @(posedge core_clk) disable iff (sys_rst)
        ##3 1'b1 |-> resultBusOe_q == $past(busEnPin, 3);
    endproperty
    a_bus_enable: assert property (p_bus_enable) else $error("bus enable does not follow select and convert");

    property p_prev_valid;
        @(posedge core_clk) disable iff (sys_rst)
        loadEn |-> int'(busyLowCnt_q) >= adc_readout_pkg::PREV_VALID_CYC;
    endproperty
    a_prev_valid: assert property (p_prev_valid) else $error("result loaded inside its valid window");

    property p_prev_held;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(busyN_q) |-> !loadEn [*8] ##1 !loadEn [*8] ##1 !loadEn [*8];
    endproperty
    a_prev_held: assert property (p_prev_held) else $error("previous result replaced inside its valid window");

endmodule

`default_nettype wire

// *** test/host_model.sv ***
// Host model: drives the select, convert and byte select pins of the port.
// Assumes the bench calls one task at a time; pins move at the falling edge.
`timescale 1ns/100ps
`default_nettype none

module host_model
#(
    parameter int GAP_CYC = 80
)
(
    input wire logic core_clk,
    input wire logic busyN_q,
    output logic chipSelN,
    output logic readConvN,
    output logic byteSel
);
    // Pins come up idle: deselected, read mode, full word.
    initial
    begin
        chipSelN = 1'b1;
        readConvN = 1'b1;
        byteSel = 1'b0;
    end

    // Sets select and byte lane at the next falling edge.
    task automatic set_pins(input logic sel, input logic lane);
        @(negedge core_clk);
        chipSelN <= sel;
        byteSel <= lane;
    endtask

    // Convert pulse of lowCyc cycles, one more with bySel; bySel makes select fall last, abortIt skips the wait.
    task automatic conv_pulse(input int lowCyc, input logic bySel, input logic abortIt);
        int n;
        n = 0;
        // A normal start waits for busy high, then a full cycle time of acquisition.
        if (!abortIt)
        begin
            while (busyN_q !== 1'b1 && n < 100)
            begin
                @(negedge core_clk);
                n++;
            end
            repeat (GAP_CYC) @(negedge core_clk);
        end
        @(negedge core_clk);
        readConvN <= 1'b0;
        // Select rises with convert falling, then falls to start the conversion.
        if (bySel)
        begin
            chipSelN <= 1'b1;
            @(negedge core_clk);
            chipSelN <= 1'b0;
        end
        repeat (lowCyc) @(negedge core_clk);
        readConvN <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** test/test_adc_parallel_readout_control.sv ***
// Self-checking bench for the converter readout control block.
// Assumes the host model drives the pins and the bench plays the converter core.
`timescale 1ns/100ps
`default_nettype none

module test_adc_parallel_readout_control;
    logic core_clk = 1'b0; // Core clock, 50 ns period.
    logic sys_rst = 1'b1; // Reset, held for the first 20 cycles.
    logic [15:0] convWord = 16'h0000; // Converter core result.
    logic chipSelN, readConvN, byteSel, busyN_q, sampleHold_q, resultBusOe_q;
    logic [15:0] result_bus;
    logic [15:0] prevWord = 16'h0000; // Last result loaded to the bus.
    logic [31:0] seed = 32'h0000_aef2; // Xorshift state.
    int err_count = 0;
    int cmp_count = 0;

    // Clock generator.
    always #25 core_clk = ~core_clk;

    adc_readout_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .chipSelN(chipSelN),
        .readConvN(readConvN), .byteSel(byteSel), .convWord(convWord), .busyN_q(busyN_q),
        .sampleHold_q(sampleHold_q), .result_bus(result_bus), .resultBusOe_q(resultBusOe_q));

    host_model host (.core_clk(core_clk), .busyN_q(busyN_q), .chipSelN(chipSelN),
        .readConvN(readConvN), .byteSel(byteSel));

    // Xorshift step for repeatable random stimulus.
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected bus word for a lane choice: lane 1 swaps the bytes.
    function automatic logic [15:0] lanes(input logic [15:0] w, input logic sel);
        return sel ? {w[7:0], w[15:8]} : w;
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A wait that ran out of bound counts as a mismatch and closes the run.
    task automatic hang();
        err_count++;
        complete_run();
    endtask

    // Compares one value with its expectation.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Steps to just after the next falling edge, where outputs are settled.
    task automatic tick();
        @(negedge core_clk);
        #1;
    endtask

    // Counts cycles until busy shows level lvl, within a bound.
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busyN_q !== lvl)
        begin
            tick();
            n++;
            if (n > 200)
                hang();
        end
    endtask

    // Waits for select and convert both low, within a bound.
    task automatic wait_start();
        int n;
        n = 0;
        while (!(chipSelN === 1'b0 && readConvN === 1'b0))
        begin
            tick();
            n++;
            if (n > 400)
                hang();
        end
    endtask

    // One full conversion, watching the bus and busy throughout.
    task automatic run_conv(input int lowCyc, input logic bySel, input logic lane);
        int n;
        logic [15:0] newWord;
        logic [15:0] lastBus;
        newWord = 16'(next_rand());
        host.set_pins(1'b0, lane);
        convWord = newWord;
        lastBus = 16'h0000;
        fork
            host.conv_pulse(lowCyc, bySel, 1'b0);
            begin
                wait_start();
                wait_busy(1'b0, n);
                chk(16'(n), 16'h0003);
                chk({15'h0, sampleHold_q}, 16'h0001);
                if (lowCyc > 1)
                    chk({15'h0, resultBusOe_q}, 16'h0000);
                // Old data must hold for the validity window while busy is low.
                while (busyN_q === 1'b0)
                begin
                    lastBus = result_bus;
                    if (resultBusOe_q === 1'b1 && n < adc_readout_pkg::PREV_VALID_CYC)
                        chk(result_bus, lanes(prevWord, lane));
                    tick();
                    n++;
                    if (n > 60)
                        hang();
                end
                chk({15'h0, n <= adc_readout_pkg::CONV_MAX_CYC}, 16'h0001);
                chk(lastBus, lanes(newWord, lane));
                chk(result_bus, lanes(newWord, lane));
                chk({14'h0, sampleHold_q, resultBusOe_q}, 16'h0001);
            end
        join
        prevWord = newWord;
        host.set_pins(1'b0, ~lane);
        repeat (4) tick();
        chk(result_bus, lanes(newWord, ~lane));
    endtask

    // Starts a conversion, then aborts it with a second convert pulse.
    task automatic run_abort();
        int n;
        int bad;
        host.set_pins(1'b0, 1'b0);
        convWord = 16'(next_rand());
        host.conv_pulse(2, 1'b0, 1'b0);
        wait_busy(1'b0, n);
        repeat (10) tick();
        bad = 0;
        fork
            host.conv_pulse(2, 1'b0, 1'b1);
            begin
                wait_start();
                wait_busy(1'b1, n);
                chk(16'(n), 16'h0003);
            end
        join
        // Nothing restarts after the abort, and the old result stays.
        repeat (20)
        begin
            tick();
            if (busyN_q !== 1'b1)
                bad++;
        end
        chk(16'(bad), 16'h0000);
        chk(result_bus, prevWord);
    endtask

    // Main sequence: reset, corner cases, abort, bus release, random runs.
    initial
    begin
        int i;
        repeat (20) @(negedge core_clk);
        chk({13'h0, busyN_q, sampleHold_q, resultBusOe_q}, 16'h0004);
        chk(result_bus, 16'h0000);
        sys_rst = 1'b0;
        run_conv(1, 1'b0, 1'b0);
        run_conv(35, 1'b0, 1'b1);
        run_conv(2, 1'b1, 1'b0);
        run_abort();
        run_conv(3, 1'b0, 1'b0);
        host.set_pins(1'b1, 1'b0);
        repeat (4) tick();
        chk({15'h0, resultBusOe_q}, 16'h0000);
        for (i = 0; i < 8; i++)
            run_conv(1 + int'(next_rand() % 34), 1'(next_rand()), 1'(next_rand()));
        complete_run();
    end
endmodule
`default_nettype wire
